// ===== srf_pkg.sv
// Package with register map, message bytes, formats and states of the speed report formatter.
package srf_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_PERIOD  = 8'h04;
    localparam logic [7:0] OFF_TARGET  = 8'h08;
    localparam logic [7:0] OFF_FAST    = 8'h0C;
    localparam logic [7:0] OFF_PATROL  = 8'h10;
    localparam logic [7:0] OFF_LOCKED  = 8'h14;
    localparam logic [7:0] OFF_FLAGS   = 8'h18;
    localparam logic [7:0] OFF_POLL    = 8'h1C;
    localparam logic [7:0] OFF_STATUS  = 8'h20;

    // Control register fields.
    localparam int CTRL_FMT_LSB   = 0;
    localparam int CTRL_DIR_EN    = 3;
    localparam int CTRL_TENTHS    = 4;
    localparam int CTRL_MULTIDROP = 5;
    localparam int CTRL_ENABLE    = 6;
    localparam int CTRL_W         = 7;

    // Flags register fields.
    localparam int FLG_TX_ON      = 0;
    localparam int FLG_LOCKED     = 1;
    localparam int FLG_ZONE_SAME  = 2;
    localparam int FLG_FORK       = 3;
    localparam int FLG_FAST_LOCK  = 4;
    localparam int FLG_FASTER_EN  = 5;
    localparam int FLG_LOW_VOLT   = 6;
    localparam int FLG_DIR_LSB    = 8;
    localparam int FLG_W          = 10;

    // Status register fields.
    localparam int STS_BUSY       = 0;
    localparam int STS_LEVEL_LSB  = 1;
    localparam int STS_COUNT_LSB  = 16;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RST   = 7'h00;
    localparam logic [31:0]       PERIOD_RST = 32'h0000_0000;
    localparam logic [11:0]       SPEED_RST  = 12'h000;
    localparam logic [FLG_W-1:0]  FLAGS_RST  = 10'h000;

    // Message bytes.
    localparam logic [7:0] ASC_ZERO  = 8'h30;
    localparam logic [7:0] ASC_CR    = 8'h0D;
    localparam logic [7:0] ASC_S     = 8'h53;
    localparam logic [7:0] ASC_POINT = 8'h2E;
    localparam logic [7:0] ASC_PLUS  = 8'h2B;
    localparam logic [7:0] ASC_MINUS = 8'h2D;
    localparam logic [7:0] ASC_QUERY = 8'h3F;
    localparam logic [7:0] TYPE_ALL  = 8'h81;
    localparam logic [1:0] STAT_TOP  = 2'h1;
    localparam logic [7:0] CKSUM_MASK = 8'h7F;

    // Speed limits and message geometry.
    localparam logic [11:0] MAX3    = 12'h3E7;
    localparam logic [11:0] MAX2    = 12'h063;
    localparam logic [11:0] TEN     = 12'h00A;
    localparam int          MSG_MAX = 16;
    localparam logic [4:0]  LEN_FOUR   = 5'h04;
    localparam logic [4:0]  LEN_ALL    = 5'h10;
    localparam logic [4:0]  LEN_CKSUM  = 5'h05;
    localparam logic [4:0]  LEN_TENTHS = 5'h06;

    // Direction codes in the flags register.
    localparam logic [1:0] DIR_UNKNOWN  = 2'h0;
    localparam logic [1:0] DIR_APPROACH = 2'h1;
    localparam logic [1:0] DIR_RECEDE   = 2'h2;

    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [2:0] {
        FMT_STRONG = 3'b000,
        FMT_FAST   = 3'b001,
        FMT_ALL    = 3'b010,
        FMT_DIR    = 3'b011,
        FMT_CKSUM  = 3'b100,
        FMT_TENTHS = 3'b101
    } srf_fmt_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } srf_state_t;

endpackage

// ===== srf_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module srf_fifo
    import srf_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    // Clock, reset and enable.
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       ce,
    // Fill side.
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Drain side.
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    // Fill level.
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign level     = cnt_r;
    assign do_wr     = ce && in_valid && in_ready;
    assign do_rd     = ce && out_valid && out_ready;

    always_ff @(posedge pclk)
    begin
        if (do_wr)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_r <= wr_r + AW'(1);
            end
            if (do_rd)
            begin
                rd_r <= rd_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // srf_fifo

// ===== srf_formatter.sv
// Speed report formatter: APB registers, message builder, serializer and output FIFO.
//
// Behaviour
// [RULE_01] Strong format: three ASCII digits of strong speed, hundreds first, then CR.
// [RULE_02] Fast format: three ASCII digits of faster speed, hundreds first, then CR.
// [RULE_03] With tenths resolution report ten times the speed, no decimal point.
// [RULE_04] All-speeds: 0x81, two status bytes, patrol, locked, faster, target digits, CR.
// [RULE_05] Status one bits 7:6 are 01; bit 0 shows transmitter on.
// [RULE_06] Status one bit 5 is set while a speed is locked.
// [RULE_07] Status one: zone in bit 4, fork in bit 3, bit 2 low, bit 1 high.
// [RULE_08] Status two bits 7:6 are 01, bits 5:4 are 00, bit 0 is 0.
// [RULE_09] Status two: fast lock bit 3, faster enabled bit 2, low voltage bit 1.
// [RULE_10] Direction format: optional direction byte, three digits, CR; five or four bytes.
// [RULE_11] Direction byte only when enabled: plus approaching, minus receding, query unknown.
// [RULE_12] Checksum format: optional direction, S, tens, ones, CR, checksum byte.
// [RULE_13] Checksum is the sum of all earlier message bytes, low seven bits.
// [RULE_14] Software should not pick tenths with the checksum format.
// [RULE_15] Tenths format: optional direction, three digits, point, tenths digit, CR.
// [RULE_16] Software should select tenths resolution with the tenths format.
// [RULE_17] Software must choose a baud rate fast enough for each format.
// [RULE_18] Point-to-point sends at the message period; multidrop sends one message per poll. Two polls during one message yield one message here.
// [RULE_19] Speed digits are ASCII 0 to 9 made by decimal conversion.
`timescale 1ns/1ps
module srf_formatter
    import srf_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Byte stream to the serial transmitter.
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready
);
    // Clamps a value to the given limit and returns three ASCII digits.
    function automatic logic [23:0] asc3(input logic [11:0] v, input logic [11:0] lim);
        logic [11:0] c;
        c = (v > lim) ? lim : v;
        asc3 = {8'(c / 12'd100) + ASC_ZERO,
                8'((c / TEN) % TEN) + ASC_ZERO,
                8'(c % TEN) + ASC_ZERO};
    endfunction

    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0]       period_r;
    logic [11:0]       target_r;
    logic [11:0]       fast_r;
    logic [11:0]       patrol_r;
    logic [11:0]       locked_r;
    logic [FLG_W-1:0]  flags_r;
    logic [15:0]       msg_cnt_r;
    logic [31:0]       tmr_r;
    logic              pend_r;
    srf_state_t        state_r;
    logic [7:0]        msg_r [MSG_MAX];
    logic [4:0]        len_r;
    logic [3:0]        idx_r;
    logic [7:0]        sum_r;
    logic              ck_r;

    logic              wr_en;
    logic              poll;
    logic              tick;
    logic [31:0]       reload;
    logic              start;
    logic              push;
    logic              last;
    logic [7:0]        push_data;
    logic              fifo_ready;
    logic [4:0]        fifo_level;
    srf_fmt_t          fmt;
    logic              dir_on;
    logic [7:0]        dir_byte;
    logic [7:0]        st1;
    logic [7:0]        st2;
    logic [7:0]        core [MSG_MAX];
    logic [7:0]        msg_nxt [MSG_MAX];
    logic [4:0]        len_nxt;

    // APB: zero wait states; the clock enable stretches the access.
    assign pready = ce;
    assign wr_en  = psel && penable && pwrite && ce;
    assign poll   = wr_en && (paddr == OFF_POLL);

    always_comb
    begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            OFF_CTRL:   prdata = 32'(ctrl_r);
            OFF_PERIOD: prdata = period_r;
            OFF_TARGET: prdata = 32'(target_r);
            OFF_FAST:   prdata = 32'(fast_r);
            OFF_PATROL: prdata = 32'(patrol_r);
            OFF_LOCKED: prdata = 32'(locked_r);
            OFF_FLAGS:  prdata = 32'(flags_r);
            OFF_POLL:   prdata = 32'h0000_0000;
            OFF_STATUS:
            begin
                prdata[STS_BUSY]                    = (state_r == ST_SEND);
                prdata[STS_LEVEL_LSB +: 5]          = fifo_level;
                prdata[STS_COUNT_LSB +: 16]         = msg_cnt_r;
            end
            default:    pslverr = psel && penable;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= CTRL_RST;
            period_r <= PERIOD_RST;
            target_r <= SPEED_RST;
            fast_r   <= SPEED_RST;
            patrol_r <= SPEED_RST;
            locked_r <= SPEED_RST;
            flags_r  <= FLAGS_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                OFF_CTRL:   ctrl_r   <= pwdata[CTRL_W-1:0];
                OFF_PERIOD: period_r <= pwdata;
                OFF_TARGET: target_r <= pwdata[11:0];
                OFF_FAST:   fast_r   <= pwdata[11:0];
                OFF_PATROL: patrol_r <= pwdata[11:0];
                OFF_LOCKED: locked_r <= pwdata[11:0];
                OFF_FLAGS:  flags_r  <= pwdata[FLG_W-1:0];
                default:    ;
            endcase
        end
    end

    // Period timer for point-to-point streaming; a period of zero acts as one.
    assign tick = ctrl_r[CTRL_ENABLE] && !ctrl_r[CTRL_MULTIDROP] && (tmr_r == 32'h0000_0000);
    assign reload = (period_r == 32'h0000_0000) ? 32'h0000_0000 : period_r - 32'h0000_0001; // [RULE_18]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmr_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            tmr_r <= (!ctrl_r[CTRL_ENABLE] || ctrl_r[CTRL_MULTIDROP] || tick) ? reload : tmr_r - 32'h0000_0001;
        end
    end

    // A request made while a message goes out waits here; its set beats the clear, but two polls during one message yield one message.
    assign start = ce && (state_r == ST_IDLE) && pend_r && ctrl_r[CTRL_ENABLE];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_r <= 1'b0;
        end
        else if (ce)
        begin
            pend_r <= (poll && ctrl_r[CTRL_MULTIDROP]) || tick || (pend_r && !start); // [RULE_18]
        end
    end

    // Message builder.
    function automatic logic [11:0] rep(input logic [11:0] v, input logic tenths);
        rep = tenths ? v : v / TEN;
    endfunction

    assign fmt    = srf_fmt_t'(ctrl_r[CTRL_FMT_LSB +: 3]);
    assign dir_on = ctrl_r[CTRL_DIR_EN] && (fmt == FMT_DIR || fmt == FMT_CKSUM || fmt == FMT_TENTHS); // [RULE_11]
    assign dir_byte = (flags_r[FLG_DIR_LSB +: 2] == DIR_APPROACH) ? ASC_PLUS :
                      (flags_r[FLG_DIR_LSB +: 2] == DIR_RECEDE)   ? ASC_MINUS : ASC_QUERY; // [RULE_11]
    assign st1 = {STAT_TOP, flags_r[FLG_LOCKED], flags_r[FLG_ZONE_SAME], flags_r[FLG_FORK],
                  2'h1, flags_r[FLG_TX_ON]}; // [RULE_05] [RULE_06] [RULE_07]
    assign st2 = {STAT_TOP, 2'h0, flags_r[FLG_FAST_LOCK], flags_r[FLG_FASTER_EN],
                  flags_r[FLG_LOW_VOLT], 1'b0}; // [RULE_08] [RULE_09]

    always_comb
    begin
        logic        tn;
        logic [23:0] d;
        tn = ctrl_r[CTRL_TENTHS];
        d = 24'h00_0000;
        core = '{default: 8'h00};
        len_nxt = LEN_FOUR;
        case (fmt)
            FMT_FAST:
            begin
                {core[0], core[1], core[2]} = asc3(rep(fast_r, tn), MAX3); // [RULE_02] [RULE_03]
                core[3] = ASC_CR;
            end
            FMT_ALL:
            begin
                core[0] = TYPE_ALL; // [RULE_04]
                core[1] = st1;
                core[2] = st2;
                {core[3], core[4], core[5]}    = asc3(rep(patrol_r, tn), MAX3);
                {core[6], core[7], core[8]}    = asc3(rep(locked_r, tn), MAX3);
                {core[9], core[10], core[11]}  = asc3(rep(fast_r, tn), MAX3);
                {core[12], core[13], core[14]} = asc3(rep(target_r, tn), MAX3);
                core[15] = ASC_CR;
                len_nxt  = LEN_ALL;
            end
            FMT_CKSUM:
            begin
                d = asc3(rep(target_r, tn), MAX2);
                core[0] = ASC_S; // [RULE_12]
                {core[1], core[2]} = d[15:0];
                core[3] = ASC_CR;
                len_nxt = LEN_CKSUM;
            end
            FMT_TENTHS:
            begin
                {core[0], core[1], core[2]} = asc3(target_r / TEN, MAX3); // [RULE_15]
                core[3] = ASC_POINT;
                core[4] = 8'(target_r % TEN) + ASC_ZERO;
                core[5] = ASC_CR;
                len_nxt = LEN_TENTHS;
            end
            default:
            begin
                {core[0], core[1], core[2]} = asc3(rep(target_r, tn), MAX3); // [RULE_01] [RULE_03] [RULE_19]
                core[3] = ASC_CR;
            end
        endcase
        // The direction byte, when present, leads and pushes the rest one place on.
        msg_nxt[0] = dir_on ? dir_byte : core[0]; // [RULE_10]
        for (int i = 1; i < MSG_MAX; i++)
        begin
            msg_nxt[i] = dir_on ? core[i-1] : core[i];
        end
        len_nxt = len_nxt + 5'(dir_on); // [RULE_10] [RULE_12] [RULE_15]
    end

    // Serializer into the FIFO; it stalls while the FIFO is full.
    assign last      = (5'(idx_r) == len_r - 5'h01);
    assign push      = ce && (state_r == ST_SEND) && fifo_ready;
    assign push_data = (ck_r && last) ? (sum_r & CKSUM_MASK) : msg_r[idx_r]; // [RULE_13]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r   <= ST_IDLE;
            idx_r     <= 4'h0;
            len_r     <= LEN_FOUR;
            sum_r     <= 8'h00;
            ck_r      <= 1'b0;
            msg_cnt_r <= 16'h0000;
            msg_r     <= '{default: 8'h00};
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        msg_r   <= msg_nxt;
                        len_r   <= len_nxt;
                        ck_r    <= (fmt == FMT_CKSUM);
                        idx_r   <= 4'h0;
                        sum_r   <= 8'h00;
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND:
                begin
                    if (push)
                    begin
                        sum_r <= sum_r + push_data; // [RULE_13]
                        idx_r <= idx_r + 4'h1;
                        if (last)
                        begin
                            state_r   <= ST_IDLE;
                            msg_cnt_r <= msg_cnt_r + 16'h0001;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    srf_fifo #(.WIDTH (FIFO_WIDTH), .DEPTH (FIFO_DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data),
        .level     (fifo_level)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cr_last_a: assert property (push && last && !ck_r |-> push_data == ASC_CR) // [RULE_01]
        else $error("Message does not end in carriage return.");
    cksum_cr_a: assert property (push && ck_r && last |-> $past(push_data) == ASC_CR) // [RULE_12]
        else $error("Checksum byte does not follow carriage return.");
    all_type_a: assert property (start && fmt == FMT_ALL |=> msg_r[0] == TYPE_ALL && len_r == LEN_ALL) // [RULE_04]
        else $error("All-speeds message header or length wrong.");
    stat1_bits_a: assert property (start && fmt == FMT_ALL |=> msg_r[1][7:6] == 2'h1 && msg_r[1][2:1] == 2'h1
        && msg_r[1][0] == $past(flags_r[FLG_TX_ON])) // [RULE_05]
        else $error("Status one fixed bits wrong.");
    stat1_lock_a: assert property (start && fmt == FMT_ALL |=> msg_r[1][5] == $past(flags_r[FLG_LOCKED])) // [RULE_06]
        else $error("Status one lock bit wrong.");
    stat2_bits_a: assert property (start && fmt == FMT_ALL |=> msg_r[2][7:4] == 4'h4 && !msg_r[2][0]) // [RULE_08]
        else $error("Status two fixed bits wrong.");
    dir_len_a: assert property (start && fmt == FMT_DIR |=> len_r == LEN_FOUR + 5'($past(ctrl_r[CTRL_DIR_EN]))) // [RULE_10]
        else $error("Direction format length wrong.");
    digit_ascii_a: assert property (push && fmt == FMT_STRONG && !last |-> push_data inside {[8'h30:8'h39]}) // [RULE_19]
        else $error("Speed digit is not ASCII.");
    poll_once_a: assert property (start && ctrl_r[CTRL_MULTIDROP] |=> !pend_r || $past(poll)) // [RULE_18]
        else $error("Multidrop sent without a poll.");
    cksum_val_a: assert property (push && ck_r && last |-> push_data[7] == 1'b0) // [RULE_13]
        else $error("Checksum byte has bit seven set.");

    all_msg_c: cover property (push && last && len_r == LEN_ALL);
    cksum_msg_c: cover property (push && last && ck_r);
    fifo_full_c: cover property (state_r == ST_SEND && !fifo_ready);
    poll_busy_c: cover property (poll && state_r == ST_SEND);
endmodule // srf_formatter

// ===== srf_sink.sv
// Model of the serial transmitter that drains the formatter's byte stream.
`timescale 1ns/1ps
module srf_sink
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Byte stream.
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Pace chosen by the bench.
    input  wire logic       stall,
    input  wire logic       slow
);
    logic       ph_r;
    logic [7:0] got[$];

    // A slow line takes a byte only every other cycle, as a low baud rate would.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_r     <= 1'b0;
            tx_ready <= 1'b0;
        end
        else
        begin
            ph_r     <= ~ph_r;
            tx_ready <= !stall && (!slow || ph_r);
        end
    end

    always @(posedge pclk)
    begin
        if (presetn && tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
        end
    end
endmodule // srf_sink

// ===== tb_speed_report_formatter.sv
// Self-checking bench for the speed report formatter.
`timescale 1ns/1ps
module tb_speed_report_formatter;
    import srf_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] r;
    logic        e;
    logic [7:0]  exp_q[$];
    logic [7:0]  fl;
    logic [7:0]  sum;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #2 pclk = ~pclk;

    srf_formatter dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    srf_sink sink (.pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .stall(stall), .slow(slow));

    task automatic wrap_up;
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // The request stays put until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic put3(input int v);
        exp_q.push_back(ASC_ZERO + 8'(v / 100));
        exp_q.push_back(ASC_ZERO + 8'((v / 10) % 10));
        exp_q.push_back(ASC_ZERO + 8'(v % 10));
    endtask

    function automatic logic [7:0] dir_ch(input int d);
        return (d == 1) ? ASC_PLUS : (d == 2) ? ASC_MINUS : ASC_QUERY;
    endfunction

    // Waiting on after the message also shows that one poll yields one message only.
    task automatic send_poll;
        int n;
        n = 0;
        apb(1'b1, OFF_POLL, 32'h0);
        while (sink.got.size() < exp_q.size() && n < 300)
        begin
            @(negedge pclk);
            n++;
        end
        repeat (30) @(negedge pclk);
        check(32'(sink.got.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            if (i < sink.got.size())
                check({24'h0, sink.got[i]}, {24'h0, exp_q[i]});
        sink.got.delete();
        exp_q.delete();
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        check(r, {25'h0, CTRL_RST});
        apb(1'b0, OFF_STATUS, 32'h0);
        check(r, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
        apb(1'b1, OFF_TARGET, 32'd234);
        apb(1'b1, OFF_CTRL, 32'h60);
        put3(23);
        exp_q.push_back(ASC_CR);
        send_poll();
        apb(1'b1, OFF_CTRL, 32'h70);
        put3(234);
        exp_q.push_back(ASC_CR);
        send_poll();
        apb(1'b1, OFF_FAST, 32'd4095);
        apb(1'b1, OFF_CTRL, 32'h71);
        put3(999);
        exp_q.push_back(ASC_CR);
        send_poll();
        apb(1'b1, OFF_PATROL, 32'd123);
        apb(1'b1, OFF_LOCKED, 32'd456);
        apb(1'b1, OFF_FAST, 32'd789);
        apb(1'b1, OFF_TARGET, 32'd1000);
        apb(1'b1, OFF_CTRL, 32'h62);
        for (int k = 0; k < 2; k++)
        begin
            fl = (k == 0) ? 8'h5B : 8'h24;
            apb(1'b1, OFF_FLAGS, {24'h0, fl});
            exp_q.push_back(TYPE_ALL);
            exp_q.push_back({2'b01, fl[1], fl[2], fl[3], 1'b0, 1'b1, fl[0]});
            exp_q.push_back({4'b0100, fl[4], fl[5], fl[6], 1'b0});
            put3(12);
            put3(45);
            put3(78);
            put3(100);
            exp_q.push_back(ASC_CR);
            send_poll();
        end
        for (int d = 0; d < 5; d++)
        begin
            apb(1'b1, OFF_FLAGS, 32'(d % 4) << 8);
            apb(1'b1, OFF_CTRL, (d < 4) ? 32'h6B : 32'h63);
            if (d < 4)
                exp_q.push_back(dir_ch(d));
            put3(100);
            exp_q.push_back(ASC_CR);
            send_poll();
        end
        // Tenths resolution stays off here because only two digits fit.
        apb(1'b1, OFF_TARGET, 32'd567);
        apb(1'b1, OFF_FLAGS, 32'h200);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFF_CTRL, (k == 0) ? 32'h6C : 32'h64);
            if (k == 0)
                exp_q.push_back(ASC_MINUS);
            exp_q.push_back(ASC_S);
            exp_q.push_back(8'h35);
            exp_q.push_back(8'h36);
            exp_q.push_back(ASC_CR);
            sum = 8'h00;
            foreach (exp_q[i])
                sum = sum + exp_q[i];
            exp_q.push_back(sum & 8'h7F);
            send_poll();
        end
        apb(1'b1, OFF_TARGET, 32'd2345);
        apb(1'b1, OFF_FLAGS, 32'h100);
        apb(1'b1, OFF_CTRL, 32'h7D);
        // The second poll lands while the first message is still going out and must be kept.
        apb(1'b1, OFF_POLL, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            exp_q.push_back(ASC_PLUS);
            put3(234);
            exp_q.push_back(ASC_POINT);
            exp_q.push_back(8'h35);
            exp_q.push_back(ASC_CR);
        end
        send_poll();
        apb(1'b1, OFF_TARGET, 32'd234);
        apb(1'b1, OFF_PERIOD, 32'd8);
        @(posedge pclk);
        stall <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h40);
        repeat (200) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        check({27'h0, r[5:1]}, 32'd16);
        check({31'h0, tx_valid}, 32'h1);
        stall <= 1'b0;
        slow <= 1'b1;
        repeat (400) @(posedge pclk);
        apb(1'b1, OFF_CTRL, 32'h0);
        repeat (200) @(posedge pclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        check({26'h0, r[5:0]}, 32'h0);
        check(32'(sink.got.size() >= 80), 32'h1);
        check(32'(sink.got.size() % 4), 32'h0);
        foreach (sink.got[i])
            check({24'h0, sink.got[i]}, (i % 4 == 3) ? 32'h0D : 32'h30 + 32'((i % 4 == 0) ? 0 : 1 + i % 4));
        wrap_up();
    end
endmodule // tb_speed_report_formatter
